// ### verilog/cmsd_decoder.sv
// Memory-space decoder for the microcontroller core: steers each access
// to general-purpose RAM, special function space, extended RAM or code.
// Assumes the execution logic drives requests on the same core clock.
//
// Operation
// - Direct or indirect addresses 0x00-0x7F go to lower general RAM.
// - Indirect addresses 0x80-0xFF go to upper general RAM, never special space.
// - Special registers at 0x80-0xFF, reached only by direct and bit modes.
// - Bit address 0x00-0x7F selects byte 0x20+addr/8, bit addr mod 8.
// - 256-byte extended RAM, selected only by the two extended modes.
// - No external RAM; extended accesses always hit on-chip extended RAM.
// - Code lives in 16 kB on-chip space; data reads use code indirect mode.
// - Port pins never act as an external bus; all accesses stay on chip.
// - Immediate pointer load: 3 bytes, 3 cycles; accumulator load: 2 and 2.
// - Extended reads, pointer or register addressed: 1 byte, 4 cycles.
// - Code reads at accumulator plus pointer or counter: 1 byte, 4 cycles.
// - Indirect jump to accumulator plus pointer: 1 byte, 3 cycles.
// - Power control byte at 0x87 is byte-only, never bit addressed.
// - Pointer-addressed extended access uses full pointer; register uses 8 bits.
`timescale 1ns/100ps
module cmsd_decoder
   import cmsd_pkg::*;
#(
   parameter int CODE_AW = CMSD_CODE_AW
)
(
   input wire logic CLK_IN, // Core clock
   input wire logic RST_N_IN, // Synchronous reset, active low
   input wire logic REQ_IN, // Access request strobe
   input wire cmsd_mode_t MODE_IN, // Addressing mode
   input wire logic WR_IN, // Write when high
   input wire logic [7:0] ADDR_IN, // Direct, register or bit address
   input wire logic [7:0] WDATA_IN, // Write data
   input wire logic [15:0] PTR_IN, // Data pointer pair value
   input wire logic [15:0] PC_IN, // Program counter value
   input wire logic [7:0] ACC_IN, // Accumulator value
   input wire cmsd_class_t CLASS_IN, // Instruction class for cost lookup
   output logic VALID_OUT, // Decode result valid pulse
   output cmsd_target_t TARGET_OUT, // Selected memory space
   output logic [7:0] RAM_ADDR_OUT, // General RAM byte address
   output logic BIT_SEL_OUT, // Single-bit access
   output logic [2:0] BIT_POS_OUT, // Bit position inside byte
   output logic [7:0] SPEC_ADDR_OUT, // Special register byte address
   output logic [15:0] EXT_RAM_ADDR_OUT, // Extended RAM address
   output logic [CODE_AW-1:0] CODE_ADDR_OUT, // Code space address
   output logic JUMP_OUT, // Code address is a jump target
   output logic [7:0] SPEC_RDATA_OUT, // Read data from local special space
   output logic [7:0] POWER_CTRL_OUT, // Power control byte contents
   output logic [1:0] INSTR_BYTES_OUT, // Instruction length in bytes
   output logic [3:0] INSTR_CYCLES_OUT, // Instruction core cycles
   output logic EXT_BUS_OE_OUT // External bus drive enable, never set
);

   // ***************************************************
   // Parameter check
   // ***************************************************
   if (CODE_AW < 1 || CODE_AW > 16)
   begin : g_bad_aw
      $error("CODE_AW must be between 1 and 16");
   end

   // ***************************************************
   // Cost lookup
   // ***************************************************
   function automatic logic [5:0] cost_of(input cmsd_class_t c);
      logic [5:0] r;
      r = {CMSD_BYTES_NONE, CMSD_CYC_NONE};
      case (c)
         CMSD_C_MOV_A_IMM: r = {CMSD_BYTES_2, CMSD_CYC_2};
         CMSD_C_MOV_PTR_IMM: r = {CMSD_BYTES_3, CMSD_CYC_3};
         CMSD_C_MOV_A_REG: r = {CMSD_BYTES_1, CMSD_CYC_1};
         CMSD_C_MOV_A_DIR: r = {CMSD_BYTES_2, CMSD_CYC_2};
         CMSD_C_MOV_A_IND: r = {CMSD_BYTES_1, CMSD_CYC_2};
         CMSD_C_EXT_PTR: r = {CMSD_BYTES_1, CMSD_CYC_4};
         CMSD_C_EXT_REG: r = {CMSD_BYTES_1, CMSD_CYC_4};
         CMSD_C_CODE_PTR: r = {CMSD_BYTES_1, CMSD_CYC_4};
         CMSD_C_CODE_PC: r = {CMSD_BYTES_1, CMSD_CYC_4};
         CMSD_C_JMP_PTR: r = {CMSD_BYTES_1, CMSD_CYC_3};
         default: r = {CMSD_BYTES_NONE, CMSD_CYC_NONE};
      endcase
      return r;
   endfunction

   // ***************************************************
   // State
   // ***************************************************
   logic valid_r, valid_nxt;
   cmsd_target_t target_r, target_nxt;
   logic [7:0] ram_addr_r, ram_addr_nxt;
   logic bit_sel_r, bit_sel_nxt;
   logic [2:0] bit_pos_r, bit_pos_nxt;
   logic [7:0] spec_addr_r, spec_addr_nxt;
   logic [15:0] ext_addr_r, ext_addr_nxt;
   logic [CODE_AW-1:0] code_addr_r, code_addr_nxt;
   logic jump_r, jump_nxt;
   logic [7:0] spec_rdata_r, spec_rdata_nxt;
   logic [7:0] pctl_r, pctl_nxt;
   logic [1:0] bytes_r, bytes_nxt;
   logic [3:0] cycles_r, cycles_nxt;
   logic [15:0] ptr_sum;
   logic [15:0] pc_sum;
   logic upper_half;

   assign ptr_sum = PTR_IN + {8'h00, ACC_IN};
   assign pc_sum = PC_IN + {8'h00, ACC_IN};
   assign upper_half = ADDR_IN >= CMSD_SPEC_BASE;

   // ***************************************************
   // Decode
   // ***************************************************
   always_comb
   begin
      valid_nxt = REQ_IN;
      target_nxt = target_r;
      ram_addr_nxt = ram_addr_r;
      bit_sel_nxt = 1'b0;
      bit_pos_nxt = bit_pos_r;
      spec_addr_nxt = spec_addr_r;
      ext_addr_nxt = ext_addr_r;
      code_addr_nxt = code_addr_r;
      jump_nxt = 1'b0;
      spec_rdata_nxt = spec_rdata_r;
      pctl_nxt = pctl_r;
      bytes_nxt = bytes_r;
      cycles_nxt = cycles_r;
      if (REQ_IN)
      begin
         {bytes_nxt, cycles_nxt} = cost_of(CLASS_IN);
         spec_rdata_nxt = CMSD_SPEC_EMPTY;
         case (MODE_IN)
            CMSD_M_DIRECT:
            begin
               if (upper_half)
               begin
                  target_nxt = CMSD_T_SPEC;
                  spec_addr_nxt = ADDR_IN;
                  if (ADDR_IN == CMSD_POWER_CTRL_ADDR)
                  begin
                     if (WR_IN)
                        pctl_nxt = WDATA_IN;
                     else
                        spec_rdata_nxt = pctl_r;
                  end
                  // Other addresses: read zero, write dropped
                  else
                     spec_rdata_nxt = CMSD_SPEC_EMPTY;
               end
               else
               begin
                  target_nxt = CMSD_T_GPRAM;
                  ram_addr_nxt = ADDR_IN;
               end
            end
            CMSD_M_INDIRECT:
            begin
               // Upper half is RAM here, the special space is shadowed
               target_nxt = CMSD_T_GPRAM;
               ram_addr_nxt = ADDR_IN;
            end
            CMSD_M_BIT:
            begin
               bit_sel_nxt = 1'b1;
               bit_pos_nxt = ADDR_IN[2:0];
               if (upper_half)
               begin
                  // Bit bytes sit on multiples of eight, so 0x87 is never hit
                  target_nxt = CMSD_T_SPEC;
                  spec_addr_nxt = {ADDR_IN[7:3], 3'h0};
               end
               else
               begin
                  target_nxt = CMSD_T_GPRAM;
                  ram_addr_nxt = CMSD_BIT_RAM_BASE + {4'h0, ADDR_IN[6:3]};
               end
            end
            CMSD_M_EXT_PTR:
            begin
               target_nxt = CMSD_T_EXT_RAM;
               ext_addr_nxt = PTR_IN;
            end
            CMSD_M_EXT_REG:
            begin
               target_nxt = CMSD_T_EXT_RAM;
               ext_addr_nxt = {8'h00, ADDR_IN};
            end
            CMSD_M_CODE_PTR:
            begin
               target_nxt = CMSD_T_CODE;
               code_addr_nxt = ptr_sum[CODE_AW-1:0];
            end
            CMSD_M_CODE_PC:
            begin
               target_nxt = CMSD_T_CODE;
               code_addr_nxt = pc_sum[CODE_AW-1:0];
            end
            CMSD_M_JUMP_PTR:
            begin
               target_nxt = CMSD_T_CODE;
               code_addr_nxt = ptr_sum[CODE_AW-1:0];
               jump_nxt = 1'b1;
            end
            default:
               target_nxt = CMSD_T_NONE;
         endcase
      end
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
      begin
         valid_r <= 1'b0;
         target_r <= CMSD_T_NONE;
         ram_addr_r <= 8'h00;
         bit_sel_r <= 1'b0;
         bit_pos_r <= 3'h0;
         spec_addr_r <= 8'h00;
         ext_addr_r <= 16'h0000;
         code_addr_r <= '0;
         jump_r <= 1'b0;
         spec_rdata_r <= CMSD_SPEC_EMPTY;
         pctl_r <= CMSD_POWER_CTRL_RST;
         bytes_r <= CMSD_BYTES_NONE;
         cycles_r <= CMSD_CYC_NONE;
      end
      else
      begin
         valid_r <= valid_nxt;
         target_r <= target_nxt;
         ram_addr_r <= ram_addr_nxt;
         bit_sel_r <= bit_sel_nxt;
         bit_pos_r <= bit_pos_nxt;
         spec_addr_r <= spec_addr_nxt;
         ext_addr_r <= ext_addr_nxt;
         code_addr_r <= code_addr_nxt;
         jump_r <= jump_nxt;
         spec_rdata_r <= spec_rdata_nxt;
         pctl_r <= pctl_nxt;
         bytes_r <= bytes_nxt;
         cycles_r <= cycles_nxt;
      end
   end

   // ***************************************************
   // Outputs
   // ***************************************************
   assign VALID_OUT = valid_r;
   assign TARGET_OUT = target_r;
   assign RAM_ADDR_OUT = ram_addr_r;
   assign BIT_SEL_OUT = bit_sel_r;
   assign BIT_POS_OUT = bit_pos_r;
   assign SPEC_ADDR_OUT = spec_addr_r;
   assign EXT_RAM_ADDR_OUT = ext_addr_r;
   assign CODE_ADDR_OUT = code_addr_r;
   assign JUMP_OUT = jump_r;
   assign SPEC_RDATA_OUT = spec_rdata_r;
   assign POWER_CTRL_OUT = pctl_r;
   assign INSTR_BYTES_OUT = bytes_r;
   assign INSTR_CYCLES_OUT = cycles_r;
   // No external bus exists; a flop held low keeps the output registered
   logic ext_oe_r;
   always_ff @(posedge CLK_IN)
   begin
      ext_oe_r <= 1'b0;
   end
   assign EXT_BUS_OE_OUT = ext_oe_r;

   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   low_ram_a: assert property (REQ_IN && !upper_half && (MODE_IN == CMSD_M_DIRECT ||
      MODE_IN == CMSD_M_INDIRECT) |=> TARGET_OUT == CMSD_T_GPRAM &&
      RAM_ADDR_OUT == $past(ADDR_IN))
      else $error("low address not steered to general RAM");
   upper_ind_a: assert property (REQ_IN && upper_half && MODE_IN == CMSD_M_INDIRECT
      |=> TARGET_OUT == CMSD_T_GPRAM)
      else $error("indirect upper address left general RAM");
   spec_direct_a: assert property (VALID_OUT && TARGET_OUT == CMSD_T_SPEC && !BIT_SEL_OUT
      |-> $past(MODE_IN) == CMSD_M_DIRECT && SPEC_ADDR_OUT >= CMSD_SPEC_BASE)
      else $error("special space reached without direct mode");
   bit_map_a: assert property (REQ_IN && MODE_IN == CMSD_M_BIT && !upper_half
      |=> RAM_ADDR_OUT >= CMSD_BIT_RAM_BASE && RAM_ADDR_OUT <= CMSD_BIT_RAM_LAST &&
      {RAM_ADDR_OUT[3:0], BIT_POS_OUT} == $past(ADDR_IN[6:0]))
      else $error("bit address mapped to wrong byte or bit");
   ext_sel_a: assert property (VALID_OUT && TARGET_OUT == CMSD_T_EXT_RAM
      |-> $past(MODE_IN) inside {CMSD_M_EXT_PTR, CMSD_M_EXT_REG})
      else $error("extended RAM selected by wrong mode");
   ext_addr_a: assert property (REQ_IN && MODE_IN == CMSD_M_EXT_REG
      |=> EXT_RAM_ADDR_OUT[15:8] == 8'h00 && TARGET_OUT == CMSD_T_EXT_RAM)
      else $error("register extended address wider than a byte");
   code_sel_a: assert property (REQ_IN && MODE_IN == CMSD_M_CODE_PTR
      |=> TARGET_OUT == CMSD_T_CODE && CODE_ADDR_OUT == $past(ptr_sum[CODE_AW-1:0]))
      else $error("code read address wrong");
   no_ext_bus_a: assert property (##1 !EXT_BUS_OE_OUT)
      else $error("external bus enable driven");
   cost_ext_a: assert property (REQ_IN && CLASS_IN == CMSD_C_EXT_REG
      |=> INSTR_BYTES_OUT == 2'h1 && INSTR_CYCLES_OUT == 4'h4)
      else $error("extended read cost wrong");
   cost_ptr_a: assert property (REQ_IN && CLASS_IN == CMSD_C_MOV_PTR_IMM
      |=> INSTR_BYTES_OUT == 2'h3 && INSTR_CYCLES_OUT == 4'h3)
      else $error("pointer load cost wrong");
   cost_jump_a: assert property (REQ_IN && CLASS_IN == CMSD_C_JMP_PTR
      |=> INSTR_CYCLES_OUT == 4'h3 && INSTR_BYTES_OUT == 2'h1)
      else $error("indirect jump cost wrong");
   pctl_bit_a: assert property (REQ_IN && MODE_IN != CMSD_M_DIRECT
      |=> $stable(POWER_CTRL_OUT))
      else $error("power control changed by non-byte access");
   spec_empty_a: assert property (REQ_IN && MODE_IN == CMSD_M_DIRECT && upper_half &&
      ADDR_IN != CMSD_POWER_CTRL_ADDR |=> SPEC_RDATA_OUT == 8'h00 &&
      $stable(POWER_CTRL_OUT))
      else $error("unimplemented special address not empty");

   pctl_write_c: cover property (REQ_IN && WR_IN && MODE_IN == CMSD_M_DIRECT &&
      ADDR_IN == CMSD_POWER_CTRL_ADDR ##1 REQ_IN && !WR_IN && MODE_IN == CMSD_M_DIRECT);
   bit_ram_c: cover property (REQ_IN && MODE_IN == CMSD_M_BIT && ADDR_IN == 8'h7f);
   ext_full_c: cover property (REQ_IN && MODE_IN == CMSD_M_EXT_PTR && PTR_IN[8]);
   jump_c: cover property (REQ_IN && MODE_IN == CMSD_M_JUMP_PTR ##1 JUMP_OUT);

endmodule

// ### verilog/cmsd_pkg.sv
// Constants and types for the core memory-space decoder.
// Assumes a single core clock domain shared with the execution logic.
package cmsd_pkg;

   // ***************************************************
   // Address map
   // ***************************************************
   localparam logic [7:0] CMSD_SPEC_BASE = 8'h80;
   localparam logic [7:0] CMSD_BIT_RAM_BASE = 8'h20;
   localparam logic [7:0] CMSD_BIT_RAM_LAST = 8'h2f;
   localparam logic [7:0] CMSD_POWER_CTRL_ADDR = 8'h87;
   localparam logic [7:0] CMSD_POWER_CTRL_RST = 8'h00;
   localparam logic [7:0] CMSD_SPEC_EMPTY = 8'h00;
   localparam int CMSD_EXT_RAM_BYTES = 256;
   localparam int CMSD_CODE_KBYTES = 16;
   localparam int CMSD_CODE_AW = $clog2(CMSD_CODE_KBYTES * 1024);
   localparam int CMSD_BITPOS_W = 3;

   // ***************************************************
   // Access modes and targets
   // ***************************************************
   typedef enum logic [2:0] {
      CMSD_M_DIRECT = 3'h0,
      CMSD_M_INDIRECT = 3'h1,
      CMSD_M_BIT = 3'h2,
      CMSD_M_EXT_PTR = 3'h3,
      CMSD_M_EXT_REG = 3'h4,
      CMSD_M_CODE_PTR = 3'h5,
      CMSD_M_CODE_PC = 3'h6,
      CMSD_M_JUMP_PTR = 3'h7
   } cmsd_mode_t;

   typedef enum logic [4:0] {
      CMSD_T_NONE = 5'h01,
      CMSD_T_GPRAM = 5'h02,
      CMSD_T_SPEC = 5'h04,
      CMSD_T_EXT_RAM = 5'h08,
      CMSD_T_CODE = 5'h10
   } cmsd_target_t;

   // ***************************************************
   // Instruction classes and their costs
   // ***************************************************
   typedef enum logic [3:0] {
      CMSD_C_MOV_A_IMM = 4'h0,
      CMSD_C_MOV_PTR_IMM = 4'h1,
      CMSD_C_MOV_A_REG = 4'h2,
      CMSD_C_MOV_A_DIR = 4'h3,
      CMSD_C_MOV_A_IND = 4'h4,
      CMSD_C_EXT_PTR = 4'h5,
      CMSD_C_EXT_REG = 4'h6,
      CMSD_C_CODE_PTR = 4'h7,
      CMSD_C_CODE_PC = 4'h8,
      CMSD_C_JMP_PTR = 4'h9
   } cmsd_class_t;

   localparam logic [1:0] CMSD_BYTES_1 = 2'h1;
   localparam logic [1:0] CMSD_BYTES_2 = 2'h2;
   localparam logic [1:0] CMSD_BYTES_3 = 2'h3;
   localparam logic [3:0] CMSD_CYC_1 = 4'h1;
   localparam logic [3:0] CMSD_CYC_2 = 4'h2;
   localparam logic [3:0] CMSD_CYC_3 = 4'h3;
   localparam logic [3:0] CMSD_CYC_4 = 4'h4;
   localparam logic [1:0] CMSD_BYTES_NONE = 2'h0;
   localparam logic [3:0] CMSD_CYC_NONE = 4'h0;

endpackage

// ### sim/cmsd_core_model.sv
// Model of the core execution logic that feeds requests to the decoder.
// Assumes the bench calls issue and idle just after a rising clock edge.
`timescale 1ns/100ps
module cmsd_core_model
   import cmsd_pkg::*;
(
   output logic REQ_OUT, // Request strobe
   output cmsd_mode_t MODE_OUT, // Addressing mode
   output logic WR_OUT, // Write qualifier
   output logic [7:0] ADDR_OUT, // Address
   output logic [7:0] WDATA_OUT, // Write data
   output logic [15:0] PTR_OUT, // Pointer pair
   output logic [15:0] PC_OUT, // Program counter
   output logic [7:0] ACC_OUT, // Accumulator
   output cmsd_class_t CLASS_OUT // Instruction class
);
   initial
   begin
      REQ_OUT = 1'b0;
      MODE_OUT = CMSD_M_DIRECT;
      WR_OUT = 1'b0;
      ADDR_OUT = 8'h00;
      WDATA_OUT = 8'h00;
      PTR_OUT = 16'h0000;
      PC_OUT = 16'h0000;
      ACC_OUT = 8'h00;
      CLASS_OUT = CMSD_C_MOV_A_IMM;
   end

   // One access per call; held until the next call
   task automatic issue(input cmsd_mode_t m, input logic w, input logic [7:0] a,
      input logic [7:0] d, input logic [15:0] p, input logic [15:0] c,
      input logic [7:0] x, input cmsd_class_t k);
      REQ_OUT = 1'b1;
      MODE_OUT = m;
      WR_OUT = w;
      ADDR_OUT = a;
      WDATA_OUT = d;
      PTR_OUT = p;
      PC_OUT = c;
      ACC_OUT = x;
      CLASS_OUT = k;
   endtask

   // Idle fields flip so a stale value is never mistaken for a request
   task automatic idle();
      REQ_OUT = 1'b0;
      MODE_OUT = cmsd_mode_t'(~MODE_OUT);
      WR_OUT = ~WR_OUT;
      ADDR_OUT = ~ADDR_OUT;
      WDATA_OUT = ~WDATA_OUT;
      PTR_OUT = ~PTR_OUT;
      PC_OUT = ~PC_OUT;
      ACC_OUT = ~ACC_OUT;
      CLASS_OUT = cmsd_class_t'(~CLASS_OUT);
   endtask
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the memory-space decoder against an integer and queue model.
// Assumes the core model drives requests 1 ns after each rising edge.
`timescale 1ns/100ps
module tb_top
   import cmsd_pkg::*;
;
   localparam int CAW = 14;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic req, wr, valid, bsel, jmp, oe;
   cmsd_mode_t mode;
   cmsd_class_t cls;
   cmsd_target_t tgt_o;
   logic [7:0] addr, wdata, acc, ram_a, spa, rdata, pctl;
   logic [15:0] ptr, pc, xa;
   logic [2:0] bpos;
   logic [CAW-1:0] ca;
   logic [1:0] nb;
   logic [3:0] nc;
   int fails = 0;
   int n_checks = 0;
   int seed = 32'ha504;
   int pwr = 0;
   int cyc = 0;
   int tq[$];
   int bt[10] = '{2, 3, 1, 2, 1, 1, 1, 1, 1, 1};
   int ct[10] = '{2, 3, 1, 2, 2, 4, 4, 4, 4, 3};
   int bnd[4] = '{0, 'h7f, 'h80, 'hff};

   always #5 clk = ~clk;

   cmsd_core_model core_u (.REQ_OUT(req), .MODE_OUT(mode), .WR_OUT(wr), .ADDR_OUT(addr),
      .WDATA_OUT(wdata), .PTR_OUT(ptr), .PC_OUT(pc), .ACC_OUT(acc), .CLASS_OUT(cls));

   cmsd_decoder #(.CODE_AW(CAW)) dut_u (.CLK_IN(clk), .RST_N_IN(rst_n), .REQ_IN(req),
      .MODE_IN(mode), .WR_IN(wr), .ADDR_IN(addr), .WDATA_IN(wdata), .PTR_IN(ptr),
      .PC_IN(pc), .ACC_IN(acc), .CLASS_IN(cls), .VALID_OUT(valid), .TARGET_OUT(tgt_o),
      .RAM_ADDR_OUT(ram_a), .BIT_SEL_OUT(bsel), .BIT_POS_OUT(bpos), .SPEC_ADDR_OUT(spa),
      .EXT_RAM_ADDR_OUT(xa), .CODE_ADDR_OUT(ca), .JUMP_OUT(jmp), .SPEC_RDATA_OUT(rdata),
      .POWER_CTRL_OUT(pctl), .INSTR_BYTES_OUT(nb), .INSTR_CYCLES_OUT(nc),
      .EXT_BUS_OE_OUT(oe));

   // ***************************************************
   // Checking helpers
   // ***************************************************
   task automatic report_and_stop();
      if (fails == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input int exp, input string m);
      n_checks++;
      if (got !== 16'(exp))
      begin
         fails++;
         $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, 16'(exp));
      end
   endtask

   // Issue one access, predict every output, compare one edge later
   task automatic do_req(input cmsd_mode_t m, input logic w, input int a, input int d,
      input int p, input int c, input int x, input cmsd_class_t k);
      int tg, rd, by, cy, cad;
      // Random fields arrive sign-extended; keep only the bits the ports carry
      a &= 'hff;
      d &= 'hff;
      p &= 'hffff;
      c &= 'hffff;
      x &= 'hff;
      core_u.issue(m, w, 8'(a), 8'(d), 16'(p), 16'(c), 8'(x), k);
      rd = (m == CMSD_M_DIRECT && !w && a == 'h87) ? pwr : 0;
      if (m == CMSD_M_DIRECT && w && a == 'h87)
         pwr = d;
      if (m == CMSD_M_DIRECT || m == CMSD_M_BIT)
         tg = (a < 'h80) ? 2 : 4;
      else
         tg = (m == CMSD_M_INDIRECT) ? 2 : ((m <= CMSD_M_EXT_REG) ? 8 : 16);
      tq.push_back(tg);
      cad = (((m == CMSD_M_CODE_PC) ? c : p) + x) % (1 << CAW);
      by = (k < 10) ? bt[k] : 0;
      cy = (k < 10) ? ct[k] : 0;
      @(posedge clk);
      #1;
      chk(16'(valid), 1, "valid");
      chk(16'(tgt_o), tq.pop_front(), "target");
      if (tg == 2)
         chk(16'(ram_a), (m == CMSD_M_BIT) ? 'h20 + a / 8 : a, "ram addr");
      chk(16'(bsel), m == CMSD_M_BIT, "bit sel");
      if (m == CMSD_M_BIT)
         chk(16'(bpos), a % 8, "bit pos");
      if (tg == 4)
         chk(16'(spa), (m == CMSD_M_BIT) ? (a & 'hf8) : a, "special addr");
      if (tg == 8)
         chk(xa, (m == CMSD_M_EXT_PTR) ? p : a, "extended addr");
      if (tg == 16)
         chk(16'(ca), cad, "code addr");
      chk(16'(jmp), m == CMSD_M_JUMP_PTR, "jump");
      chk(16'(rdata), rd, "sfr rdata");
      chk(16'(pctl), pwr, "power byte");
      chk(16'(nb), by, "bytes");
      chk(16'(nc), cy, "cycles");
      chk(16'(oe), 0, "ext bus");
   endtask

   task automatic idle_chk();
      core_u.idle();
      @(posedge clk);
      #1;
      chk(16'(valid), 0, "idle valid");
      chk(16'(bsel | jmp), 0, "idle pulse");
   endtask

   // ***************************************************
   // Stimulus
   // ***************************************************
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fails++;
         report_and_stop();
      end
   end

   initial
   begin
      repeat (5) @(posedge clk);
      #1;
      chk(16'(tgt_o), 1, "rst target");
      chk(16'(valid), 0, "rst valid");
      chk(16'({pctl, nb, nc}), 0, "rst regs");
      rst_n = 1'b1;
      @(posedge clk);
      #1;
      do_req(CMSD_M_DIRECT, 1, 'h87, 'h5a, 0, 0, 0, CMSD_C_MOV_A_DIR);
      do_req(CMSD_M_DIRECT, 0, 'h87, 0, 0, 0, 0, CMSD_C_MOV_A_DIR);
      do_req(CMSD_M_DIRECT, 1, 'h88, 'hff, 0, 0, 0, CMSD_C_MOV_A_DIR);
      do_req(CMSD_M_DIRECT, 0, 'h88, 0, 0, 0, 0, CMSD_C_MOV_A_DIR);
      do_req(CMSD_M_INDIRECT, 1, 'h87, 'h11, 0, 0, 0, CMSD_C_MOV_A_IND);
      do_req(CMSD_M_BIT, 1, 'h87, 'h00, 0, 0, 0, CMSD_C_MOV_A_REG);
      do_req(CMSD_M_DIRECT, 0, 'h87, 0, 0, 0, 0, CMSD_C_MOV_A_DIR);
      for (int i = 0; i < 8; i++)
         foreach (bnd[j])
            do_req(cmsd_mode_t'(i), 0, bnd[j], 0, 'hffff, 'hfff0, 'h20, cmsd_class_t'(i));
      for (int k = 0; k < 16; k++)
         do_req(CMSD_M_INDIRECT, 0, 'h10, 0, 0, 0, 0, cmsd_class_t'(k));
      repeat (300)
      begin
         if ($random(seed) % 4 == 0)
            idle_chk();
         do_req(cmsd_mode_t'(3'($random(seed))), 1'($random(seed)), 8'($random(seed)),
            8'($random(seed)), 16'($random(seed)), 16'($random(seed)), 8'($random(seed)),
            cmsd_class_t'(4'($random(seed))));
      end
      // Mid-run reset must clear the power byte again
      do_req(CMSD_M_DIRECT, 1, 'h87, 'h3c, 0, 0, 0, CMSD_C_MOV_A_DIR);
      core_u.idle();
      rst_n = 1'b0;
      @(posedge clk);
      #1;
      rst_n = 1'b1;
      pwr = 0;
      chk(16'(pctl), 0, "rerst power");
      chk(16'(tgt_o), 1, "rerst target");
      chk(16'(valid), 0, "rerst valid");
      @(posedge clk);
      #1;
      do_req(CMSD_M_DIRECT, 0, 'h87, 0, 0, 0, 0, CMSD_C_MOV_A_DIR);
      report_and_stop();
   end
endmodule
